// *** connectivity_test_xor_tree.sv ***
// Top of the pin connectivity test logic: synchronisers, mode sequencing,
// output mapping and pin enables.
// Assumes test pins arrive asynchronously and the pads resolve the wire
// level from the output enables; normal memory logic reads the mode flags.
`timescale 1ns/1ns
`include "ct_regs.svh"
module connectivity_test_xor_tree
   import ct_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ten,
   input wire logic cs_n,
   input wire logic [16:0] addr,
   input wire logic [1:0] ba,
   input wire logic [1:0] bg,
   input wire logic act_n,
   input wire logic cke,
   input wire logic odt,
   input wire logic ck_t,
   input wire logic ck_c,
   input wire logic par,
   input wire logic alert_n,
   input wire logic ldm_n,
   input wire logic udm_n,
   input wire logic reset_n,
   input wire logic sixteen_bit_org_flag,
   input wire logic eight_bit_org_flag,
   output logic [15:0] dq_out,
   output logic [15:0] dq_oe,
   output logic dqsl_t_out,
   output logic dqsl_c_out,
   output logic dqsl_oe,
   output logic dqsu_t_out,
   output logic dqsu_c_out,
   output logic dqsu_oe,
   output logic pin_continuity_test,
   output logic clk_ignore,
   output logic refresh_block,
   output logic odt_off,
   output logic reinit_required
);

   // =====================================================================
   // Functions
   // =====================================================================

   // Organisation from the two flags
   function automatic org_t org_of(input logic f16, input logic f8);
      if (f16) begin
         return ORG_X16;
      end else if (f8) begin
         return ORG_X8;
      end
      return ORG_X4;
   endfunction

   // Data pin values for each organisation
   function automatic logic [15:0] map_dq(input logic [9:0] t, input org_t org);
      logic [15:0] v;
      v = 16'h0000;
      unique case (org)
         ORG_X16: begin
            for (int i = 0; i < 6; i++) begin
               v[2*i] = t[i];
               v[2*i+1] = ~t[i];
            end
            v[12] = t[6];
            v[13] = t[7];
            v[14] = t[8];
            v[15] = ~t[8];
         end
         ORG_X8: begin
            v[7:0] = t[7:0];
         end
         ORG_X4: begin
            for (int i = 0; i < 4; i++) begin
               v[i] = t[2*i] ^ t[2*i+1];
            end
         end
      endcase
      return v;
   endfunction

   // Data pins enabled for each organisation
   function automatic logic [15:0] dq_width_mask(input org_t org);
      logic [15:0] m;
      m = 16'h000F;
      unique case (org)
         ORG_X16: m = 16'hFFFF;
         ORG_X8:  m = 16'h00FF;
         ORG_X4:  m = 16'h000F;
      endcase
      return m;
   endfunction

   // =====================================================================
   // Pin synchronisers
   // =====================================================================

   localparam int SYNC_W = 35;

   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] meta_d;
   logic [SYNC_W-1:0] pins_q;
   logic [SYNC_W-1:0] pins_d;

   assign pins_raw = {ten, cs_n, addr, ba, bg, act_n, cke, odt, ck_t, ck_c, par,
                      alert_n, ldm_n, udm_n, reset_n, sixteen_bit_org_flag,
                      eight_bit_org_flag};

   // Two stage capture; only pins_q is read by logic
   always_comb begin
      meta_d = pins_raw;
      pins_d = meta_q;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q <= '0;
         pins_q <= '0;
      end else begin
         meta_q <= meta_d;
         pins_q <= pins_d;
      end
   end

   logic ten_s;
   logic cs_n_s;
   logic [16:0] addr_s;
   logic [1:0] ba_s;
   logic [1:0] bg_s;
   logic act_n_s;
   logic cke_s;
   logic odt_s;
   logic ck_t_s;
   logic ck_c_s;
   logic par_s;
   logic alert_n_s;
   logic ldm_n_s;
   logic udm_n_s;
   logic reset_n_s;
   logic f16_s;
   logic f8_s;

   assign {ten_s, cs_n_s, addr_s, ba_s, bg_s, act_n_s, cke_s, odt_s, ck_t_s, ck_c_s,
           par_s, alert_n_s, ldm_n_s, udm_n_s, reset_n_s, f16_s, f8_s} = pins_q;

   // =====================================================================
   // Parity terms
   // =====================================================================

   logic [9:0] term;

   parity_terms u_terms (
      .addr(addr_s),
      .ba(ba_s),
      .bg(bg_s),
      .act_n(act_n_s),
      .cke(cke_s),
      .odt(odt_s),
      .ck_t(ck_t_s),
      .ck_c(ck_c_s),
      .par(par_s),
      .alert_n(alert_n_s),
      .ldm_n(ldm_n_s),
      .udm_n(udm_n_s),
      .reset_n(reset_n_s),
      .ten(ten_s),
      .sixteen_bit_org_flag(f16_s),
      .eight_bit_org_flag(f8_s),
      .parity_term(term)
   );

   // =====================================================================
   // Mode sequencing
   // =====================================================================

   ct_state_t state_q;
   ct_state_t state_d;
   logic [`CT_CNT_W-1:0] cnt_q;
   logic [`CT_CNT_W-1:0] cnt_d;
   logic reinit_q;
   logic reinit_d;

   // Entry wait, exit on TEN low, reinit flag until reset pin and TEN both low
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      reinit_d = reinit_q;
      // Clear comes first so that a new exit in the same cycle wins
      if (!reset_n_s && !ten_s) begin
         reinit_d = 1'b0;
      end
      unique case (state_q)
         CT_OFF: begin
            if (ten_s) begin
               state_d = CT_ENTER;
               cnt_d = '0;
            end
         end
         CT_ENTER: begin
            if (!ten_s) begin
               state_d = CT_OFF;
               reinit_d = 1'b1;
            end else if (cnt_q == `CT_CNT_W'(`CT_ENTRY_WAIT - 1)) begin
               state_d = CT_ACTIVE;
            end else begin
               cnt_d = cnt_q + `CT_CNT_W'(1);
            end
         end
         CT_ACTIVE: begin
            if (!ten_s) begin
               state_d = CT_OFF;
               reinit_d = 1'b1;
            end
         end
         default: begin
            state_d = CT_OFF;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= CT_OFF;
         cnt_q <= '0;
         reinit_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         reinit_q <= reinit_d;
      end
   end

   // =====================================================================
   // Output registers
   // =====================================================================

   logic [15:0] dq_q;
   logic [15:0] dq_d;
   logic [15:0] dq_oe_q;
   logic [15:0] dq_oe_d;
   logic [3:0] dqs_q;
   logic [3:0] dqs_d;
   logic [1:0] dqs_oe_q;
   logic [1:0] dqs_oe_d;
   logic [3:0] flags_q;
   logic [3:0] flags_d;
   logic drive;
   org_t org;

   assign org = org_of(f16_s, f8_s);

   // drive only with chip select low
   assign drive = (state_q == CT_ACTIVE) & ~cs_n_s;

   // Pin values and enables, one register stage after the terms
   always_comb begin
      dq_d = map_dq(term, org);
      dq_oe_d = drive ? dq_width_mask(org) : 16'h0000;
      if (org == ORG_X16) begin
         dqs_d = {~term[9], term[9], term[9], ~term[9]};
         dqs_oe_d = {drive, drive};
      end else begin
         // strobe pair on terms 8 and 9
         dqs_d = {2'b00, term[8], term[9]};
         dqs_oe_d = {1'b0, drive};
      end
      flags_d[0] = ten_s | (state_q != CT_OFF); // Held until the mode has left
      flags_d[1] = ten_s | (state_q != CT_OFF);
      flags_d[2] = ten_s | (state_q != CT_OFF);
      flags_d[3] = (state_q == CT_ACTIVE);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         dq_q <= 16'h0000;
         dq_oe_q <= 16'h0000;
         dqs_q <= 4'h0;
         dqs_oe_q <= 2'h0;
         flags_q <= 4'h0;
      end else begin
         dq_q <= dq_d;
         dq_oe_q <= dq_oe_d;
         dqs_q <= dqs_d;
         dqs_oe_q <= dqs_oe_d;
         flags_q <= flags_d;
      end
   end

   // Port connections, all from registers
   assign dq_out = dq_q;
   assign dq_oe = dq_oe_q;
   assign dqsl_t_out = dqs_q[1];
   assign dqsl_c_out = dqs_q[0];
   assign dqsu_t_out = dqs_q[3];
   assign dqsu_c_out = dqs_q[2];
   assign dqsl_oe = dqs_oe_q[0];
   assign dqsu_oe = dqs_oe_q[1];
   assign clk_ignore = flags_q[0];
   assign refresh_block = flags_q[1];
   assign odt_off = flags_q[2];
   assign pin_continuity_test = flags_q[3];
   assign reinit_required = reinit_q;

endmodule

// *** connectivity_test_xor_tree_tb_top.sv ***
// Self-checking bench for the connectivity test block.
// Assumes the design's outputs settle three edges after a pattern is driven; the patterns wait five.
`timescale 1ns/1ns
module connectivity_test_xor_tree_tb_top;
   logic core_clk, rst, ten, cs_n, act_n, cke, odt, ck_t, ck_c, par, alert_n;
   logic ldm_n, udm_n, reset_n, sixteen_bit_org_flag, eight_bit_org_flag;
   logic [16:0] addr;
   logic [1:0] ba, bg, e_so;
   logic [15:0] dq_out, dq_oe, dq_pin, e_dq, e_oe;
   logic dqsl_t_out, dqsl_c_out, dqsl_oe, dqsu_t_out, dqsu_c_out, dqsu_oe;
   logic pin_continuity_test, clk_ignore, refresh_block, odt_off, reinit_required;
   logic [3:0] e_st;
   logic [1:0] orgs [$] = '{2'b00, 2'b01, 2'b10, 2'b11};
   int n_errors, check_count, seed, k;

   connectivity_test_xor_tree dut (.*);
   dq_pad_sense pad (.core_clk(core_clk), .rst(rst), .dq_out(dq_out), .dq_oe(dq_oe),
      .dq_pin(dq_pin));

   // Free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ==========================================================
   // Checking helpers
   task fail(string m);
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask

   task chk(logic [15:0] got, logic [15:0] exp, string m);
      check_count++;
      if (got !== exp) fail(m);
   endtask

   task end_of_test;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Reference model of terms and pin mapping
   task model;
      logic [9:0] t;
      t[0] = addr[1] ^ addr[6] ^ par;
      t[1] = addr[8] ^ alert_n ^ addr[9];
      t[2] = addr[2] ^ addr[5] ^ addr[15];
      t[3] = addr[0] ^ addr[7] ^ addr[11];
      t[4] = ck_c ^ odt ^ addr[15];
      t[5] = cke ^ addr[16] ^ addr[10];
      t[6] = act_n ^ addr[4] ^ ba[1];
      t[7] = (sixteen_bit_org_flag ? udm_n : bg[1]) ^ ck_t
         ^ ((eight_bit_org_flag | sixteen_bit_org_flag) & ldm_n);
      t[8] = addr[14] ^ addr[12] ^ ba[0];
      t[9] = bg[0] ^ addr[3] ^ (reset_n & ten);
      e_dq = 16'h0;
      e_st = {2'b00, t[8], t[9]};
      e_so = 2'b01;
      if (sixteen_bit_org_flag) begin
         for (int i = 0; i < 6; i++) e_dq[2*i +: 2] = {~t[i], t[i]};
         e_dq[15:12] = {~t[8], t[8], t[7], t[6]};
         e_oe = 16'hFFFF;
         e_st = {~t[9], t[9], t[9], ~t[9]};
         e_so = 2'b11;
      end else if (eight_bit_org_flag) begin
         e_dq[7:0] = t[7:0];
         e_oe = 16'h00FF;
      end else begin
         for (int i = 0; i < 4; i++) e_dq[i] = t[2*i] ^ t[2*i+1];
         e_oe = 16'h000F;
      end
      if (cs_n) begin
         e_oe = 16'h0;
         e_so = 2'b00;
      end
   endtask

   // Drive one random pattern, wait out the settle time, compare the data and strobe outputs
   task pattern(logic cs);
      @(posedge core_clk);
      cs_n <= cs;
      addr <= 17'($random(seed));
      ba <= 2'($random(seed));
      bg <= 2'($random(seed));
      {act_n, cke, odt, ck_t, ck_c, par, alert_n, ldm_n, udm_n, reset_n} <= 10'($random(seed));
      repeat (5) @(posedge core_clk);
      #1;
      model();
      chk(dq_oe, e_oe, "data enables");
      chk(dq_pin & e_oe, e_dq & e_oe, "data terms");
      chk({14'h0, dqsu_oe, dqsl_oe}, {14'h0, e_so}, "strobe enables");
      chk({12'h0, dqsu_t_out, dqsu_c_out, dqsl_t_out, dqsl_c_out} & {12'h0, {2{e_so[1]}},
         {2{e_so[0]}}}, {12'h0, e_st & {{2{e_so[1]}}, {2{e_so[0]}}}}, "strobes");
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      seed = 32'hCACD;
      n_errors = 0;
      check_count = 0;
      {rst, ten, cs_n, addr, ba, bg} = {3'b101, 21'h0};
      {act_n, cke, odt, ck_t, ck_c, par, alert_n, ldm_n, udm_n, reset_n} = 10'h3FF;
      {sixteen_bit_org_flag, eight_bit_org_flag} = 2'b00;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk({12'h0, pin_continuity_test, clk_ignore, refresh_block, dq_oe[0]}, 16'h0, "reset");
      foreach (orgs[o]) begin
         @(posedge core_clk);
         {sixteen_bit_org_flag, eight_bit_org_flag} <= orgs[o];
         ten <= 1'b1;
         cs_n <= 1'b0;
         for (k = 0; k < 21 && pin_continuity_test !== 1'b1; k++) begin
            @(posedge core_clk);
            #1;
         end
         check_count++;
         if (k > 20) begin
            fail("test mode entry timed out");
            end_of_test();
         end
         chk({12'h0, clk_ignore, refresh_block, odt_off, reinit_required}, 16'h000E,
            "mode flags");
         for (int i = 0; i < 12; i++) pattern(i == 5 || i == 9);
         @(posedge core_clk);
         ten <= 1'b0;
         reset_n <= 1'b1; // Reset pin held high across the exit
         repeat (6) @(posedge core_clk);
         #1;
         chk({13'h0, pin_continuity_test, reinit_required, dqsl_oe}, 16'h0002, "exit");
         @(posedge core_clk);
         reset_n <= 1'b0;
         repeat (5) @(posedge core_clk);
         #1;
         chk({15'h0, reinit_required}, 16'h0, "reinit clear");
      end
      end_of_test();
   end
endmodule

// *** ct_pkg.sv ***
// Types for the pin connectivity test logic.
// Assumes ct_regs.svh supplies the numeric constants.
package ct_pkg;

   // Test mode sequencing
   typedef enum logic [1:0] {
      CT_OFF    = 2'b00,
      CT_ENTER  = 2'b01,
      CT_ACTIVE = 2'b10
   } ct_state_t;

   // Data width organisation of the part
   typedef enum logic [1:0] {
      ORG_X4  = 2'b00,
      ORG_X8  = 2'b01,
      ORG_X16 = 2'b10
   } org_t;

endpackage

// *** ct_regs.svh ***
// Constants for the pin connectivity test logic: timing and entry figures.
// Assumes a single 100 MHz core clock; included by its bare name.
//
// Function
// - Term 0 = A1^A6^PAR, term 1 = A8^ALERT^A9
// - Term 2 = A2^A5^A15, term 3 = A0^A7^A11
// - Term 4 = CK_c^ODT^CAS; term 5 = CKE^RAS^A10
// - Term 6 = ACT^A4^BA1; term 8 = WE^A12^BA0
// - Term 7 mixes mask pins, BG1, true clock
// - Term 9 = BG0^A3^(RESET and TEN)
// - Sixteen-bit: even DQ terms, odd DQ inverted; the code drives DQ13 with term 7 uninverted
// - Eight-bit: DQ0-7 terms 0-7, strobes 8,9
// - Four-bit: DQn = term 2n ^ term 2n+1
// - TEN ignores clocks; test mode within 200ns
// - No refresh while test mode active
// - TEN accepted from any device state
// - Outputs settle within 200ns of new pattern
// - Outputs driven only while chip select low
// - All termination off during test mode
`ifndef CT_REGS_SVH
`define CT_REGS_SVH

// Clock period in ns
`define CT_CLK_PERIOD_NS 10
// Longest time from TEN rising to test mode, in ns
`define CT_ENABLE_NS 200
// Longest time from new pattern to settled outputs, in ns
`define CT_VALID_NS 200
// Longest times rounded down to whole cycles
`define CT_ENABLE_CYC (`CT_ENABLE_NS / `CT_CLK_PERIOD_NS)
`define CT_VALID_CYC (`CT_VALID_NS / `CT_CLK_PERIOD_NS)
// Cycles spent in pin synchronisers, the state register and the output register
`define CT_PATH_LAT 4
// Entry wait counted inside the state machine
`define CT_ENTRY_WAIT (`CT_ENABLE_CYC - `CT_PATH_LAT)
// Width of the entry counter
`define CT_CNT_W 5

`endif

// *** ct_xor_sva.sv ***
// Checker for the connectivity test block, bound to its top ports.
// Assumes three edges from a pin change to the registered outputs.
`timescale 1ns/1ns
module ct_xor_sva (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ten,
   input wire logic cs_n,
   input wire logic [16:0] addr,
   input wire logic par,
   input wire logic alert_n,
   input wire logic sixteen_bit_org_flag,
   input wire logic [15:0] dq_out,
   input wire logic [15:0] dq_oe,
   input wire logic dqsl_t_out,
   input wire logic dqsl_oe,
   input wire logic dqsu_t_out,
   input wire logic dqsu_oe,
   input wire logic pin_continuity_test,
   input wire logic clk_ignore,
   input wire logic refresh_block,
   input wire logic odt_off,
   input wire logic reinit_required
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic [4:0] ten_cnt_d;
   logic [4:0] ten_cnt_q;
   logic t0_w;
   logic t1_w;

   // Two lowest parity terms and a saturating count of enable-high cycles
   always_comb begin
      t0_w = addr[1] ^ addr[6] ^ par;
      t1_w = addr[8] ^ alert_n ^ addr[9];
      ten_cnt_d = ten ? ten_cnt_q + {4'h0, ~&ten_cnt_q} : 5'h0;
   end

   always_ff @(posedge core_clk) begin
      ten_cnt_q <= rst ? 5'h0 : ten_cnt_d;
   end

   // ==========================================================
   // Properties
   cs_gate_a:
      assert property (dqsl_oe == (pin_continuity_test && !$past(cs_n, 3)))
      else $error("strobe enable does not follow chip select");
   upper_gate_a:
      assert property (dqsu_oe |-> $past(sixteen_bit_org_flag, 3) && dq_oe[15])
      else $error("upper strobe enabled outside sixteen-bit mode");
   wide_inv_a:
      assert property (dqsu_oe |-> dq_out[15] != dq_out[14] && dq_out[1] != dq_out[0]
         && dqsu_t_out != dqsl_t_out)
      else $error("sixteen-bit inverted outputs wrong");
   byte_term_a:
      assert property (dq_oe[7] && !dq_oe[8] |->
         dq_out[0] == $past(t0_w, 3) && dq_out[1] == $past(t1_w, 3))
      else $error("eight-bit data terms wrong");
   nibble_term_a:
      assert property (dq_oe[0] && !dq_oe[4] |-> dq_out[0] == ($past(t0_w, 3) ^ $past(t1_w, 3)))
      else $error("four-bit data term wrong");
   entry_fast_a:
      assert property ($rose(ten) |-> ##3 (clk_ignore && refresh_block && odt_off))
      else $error("clocks not ignored after test enable");
   entry_bound_a:
      assert property (ten_cnt_q >= 5'h14 |-> pin_continuity_test)
      else $error("test mode entry too slow");
   no_refresh_a:
      assert property (pin_continuity_test |-> refresh_block && odt_off && clk_ignore)
      else $error("refresh or termination active in test mode");
   exit_seq_a:
      assert property ($fell(ten) |-> ##4 reinit_required ##1 !(pin_continuity_test || dqsl_oe))
      else $error("test mode exit sequence wrong");
endmodule

bind connectivity_test_xor_tree ct_xor_sva chk (.*);

// *** dq_pad_sense.sv ***
// Tester-side model of the data pads: resolves each pin from drive and enable.
// Assumes dq_out and dq_oe come straight from the test logic outputs.
`timescale 1ns/1ns
module dq_pad_sense (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [15:0] dq_out,
   input wire logic [15:0] dq_oe,
   output logic [15:0] dq_pin
);
   logic [15:0] last_d;
   logic [15:0] last_q;

   // released pins toggle
   // A released pin shows the inverse of its last level, so it toggles
   always_comb begin
      dq_pin = (dq_out & dq_oe) | (~last_q & ~dq_oe);
      last_d = dq_pin;
   end

   // Last seen pin levels
   always_ff @(posedge core_clk) begin
      last_q <= rst ? 16'h0 : last_d;
   end
endmodule

// *** parity_terms.sv ***
// Ten exclusive-or parity terms of the pin connectivity test.
// Assumes every input is already synchronised to core_clk.
`timescale 1ns/1ns
module parity_terms
   import ct_pkg::*;
(
   input wire logic [16:0] addr,
   input wire logic [1:0] ba,
   input wire logic [1:0] bg,
   input wire logic act_n,
   input wire logic cke,
   input wire logic odt,
   input wire logic ck_t,
   input wire logic ck_c,
   input wire logic par,
   input wire logic alert_n,
   input wire logic ldm_n,
   input wire logic udm_n,
   input wire logic reset_n,
   input wire logic ten,
   input wire logic sixteen_bit_org_flag,
   input wire logic eight_bit_org_flag,
   output logic [9:0] parity_term
);

   logic term7_a;
   logic term7_b;

   // Mask pin selection by organisation
   assign term7_a = sixteen_bit_org_flag ? udm_n : bg[1];
   assign term7_b = (sixteen_bit_org_flag | eight_bit_org_flag) & ldm_n;

   // Term equations
   always_comb begin
      parity_term[0] = addr[1] ^ addr[6] ^ par;
      parity_term[1] = addr[8] ^ alert_n ^ addr[9];
      parity_term[2] = addr[2] ^ addr[5] ^ addr[15];
      parity_term[3] = addr[0] ^ addr[7] ^ addr[11];
      parity_term[4] = ck_c ^ odt ^ addr[15];
      parity_term[5] = cke ^ addr[16] ^ addr[10];
      parity_term[6] = act_n ^ addr[4] ^ ba[1];
      parity_term[8] = addr[14] ^ addr[12] ^ ba[0];
      parity_term[7] = term7_a ^ term7_b ^ ck_t;
      parity_term[9] = bg[0] ^ addr[3] ^ (reset_n & ten);
   end

endmodule
